// *** testbench/cc_host_model.sv ***
// Host controller model that drives the two-wire link of the target
`timescale 1ns/1ns

module cc_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ****************************************************************
  // Bit level
  // ****************************************************************
  // Data moves only while the clock is low; sampled midway through the high phase
  task automatic clk_bit(input logic b, output logic s);
    scl <= 1'b0;
    #20 sda_low <= ~b; // Released line rises through the pull-up
    #42 scl <= 1'b1;
    #30 s = sda;
    #33;
  endtask

  // Repeated start needs one high bit first to lift the data line
  task automatic start(input logic rep);
    logic s;
    if (rep) begin
      clk_bit(1'b1, s);
    end
    sda_low <= 1'b1;
    #62;
  endtask

  task automatic stop;
    logic s;
    clk_bit(1'b0, s);
    sda_low <= 1'b0;
    #62;
  endtask

  // ****************************************************************
  // Byte level
  // ****************************************************************
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  // Last byte of a read gets no acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, s);
  endtask
endmodule

// *** testbench/cc_i2c_target_test.sv ***
// Self-checking bench for the two-wire target interface
`timescale 1ns/1ns

module cc_i2c_target_test;
  import cc_pkg::*;
  localparam logic [3:0] HI = 4'h5;
  logic       ref_clk = 1'b0;
  logic       rst_n;
  logic [2:0] sel;
  logic       scl, sda_low, sda_out, sda_oe, slot_write, frame_send;
  logic [7:0] param_reg, slot_marker;
  logic [5:0] frame_len;
  int         err_count = 0;
  int         tests_run = 0;
  int         sends = 0;
  int         slots = 0;
  // Wired line: either party pulls low, pull-up otherwise
  wire logic  sda = ~(sda_oe | sda_low);

  always #5 ref_clk = ~ref_clk;

  cc_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
  cc_i2c_target #(.ADDR_HI(HI)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_in_bit1(sel[0]),
    .addr_select_in_bit2(sel[1]), .addr_select_in_bit3(sel[2]),
    .param_reg(param_reg), .slot_marker(slot_marker), .slot_write(slot_write),
    .frame_send(frame_send), .frame_len(frame_len));

  // One-cycle pulses are counted so no task can miss them
  always @(posedge ref_clk) begin
    if (frame_send === 1'b1) sends++;
    if (slot_write === 1'b1) slots++;
  end

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Transfers
  // ****************************************************************
  task automatic wr_reg(input logic [7:0] ra, input logic [7:0] d);
    logic a;
    host.start(1'b0);
    host.wbyte({HI, sel, 1'b0}, a);
    chk1("addr ack", 1'b1, a);
    host.wbyte(ra, a);
    chk1("subaddr ack", 1'b1, a);
    host.wbyte(d, a);
    chk1("data ack", 1'b1, a);
    host.stop;
  endtask

  task automatic rd_reg(input logic [7:0] ra, output logic [7:0] d);
    logic a;
    host.start(1'b0);
    host.wbyte({HI, sel, 1'b0}, a);
    host.wbyte(ra, a);
    host.start(1'b1);
    host.wbyte({HI, sel, 1'b1}, a);
    chk1("read addr ack", 1'b1, a);
    host.rbyte(1'b1, d);
    host.stop;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every select code answers its own address and ignores a neighbour
  task automatic t_select;
    logic a;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk) sel <= 3'(i);
      host.start(1'b0);
      host.wbyte({HI, 3'(i), 1'b0}, a);
      chk1("own address ack", 1'b1, a);
      host.stop;
      host.start(1'b0);
      host.wbyte({HI, 3'(i + 1), 1'b0}, a);
      chk1("foreign address ack", 1'b0, a);
      // Fresh address phase, so only the upper bits differ
      host.start(1'b1);
      host.wbyte({~HI, 3'(i), 1'b0}, a);
      chk1("upper address ack", 1'b0, a);
      host.stop;
    end
    $display("test select finished");
  endtask

  // Asymmetric value exposes any bit reversal
  task automatic t_param;
    logic [7:0] d;
    @(posedge ref_clk) sel <= 3'h5;
    wr_reg(8'h00, 8'h96);
    chk8("param register", 8'h96, param_reg);
    rd_reg(8'h00, d);
    chk8("param readback", 8'h96, d);
    chk1("drive value", 1'b0, sda_out);
    chk1("idle line", 1'b1, sda);
    $display("test param finished");
  endtask

  task automatic t_slot;
    int s0;
    s0 = slots;
    wr_reg(8'h03, 8'h3c);
    chk8("slot marker", 8'h3c, slot_marker);
    chk8("slot pulses", 8'h01, 8'(slots - s0));
    $display("test slot finished");
  endtask

  // Overlong frame is cut at the limit and still sent
  task automatic t_frame;
    logic a;
    logic [7:0] d;
    int s0;
    s0 = sends;
    host.start(1'b0);
    host.wbyte({HI, sel, 1'b0}, a);
    host.wbyte(8'h01, a);
    for (int i = 0; i < 37; i++) begin
      host.wbyte(8'(i + 8'h10), a);
      chk1("frame byte ack", i < 36, a);
    end
    host.stop;
    for (int k = 0; k < 30 && sends == s0; k++) @(posedge ref_clk);
    chk8("frame sends", 8'h01, 8'(sends - s0));
    chk8("frame length", 8'h24, {2'h0, frame_len});
    wr_reg(8'h01, 8'ha5);
    for (int k = 0; k < 30 && sends == s0 + 1; k++) @(posedge ref_clk);
    chk8("short length", 8'h01, {2'h0, frame_len});
    rd_reg(8'h01, d);
    chk8("frame readback", 8'ha5, d);
    $display("test frame finished");
  endtask

  // Acknowledged read steps through the frame buffer
  task automatic t_burst;
    logic       a;
    logic [7:0] d0, d1;
    host.start(1'b0);
    host.wbyte({HI, sel, 1'b0}, a);
    host.wbyte(8'h01, a);
    host.wbyte(8'hc3, a);
    host.wbyte(8'h3c, a);
    chk1("second frame ack", 1'b1, a);
    host.stop;
    chk8("burst length", 8'h02, {2'h0, frame_len});
    host.start(1'b0);
    host.wbyte({HI, sel, 1'b0}, a);
    host.wbyte(8'h01, a);
    host.start(1'b1);
    host.wbyte({HI, sel, 1'b1}, a);
    host.rbyte(1'b0, d0);
    host.rbyte(1'b1, d1);
    host.stop;
    chk8("frame byte 0", 8'hc3, d0);
    chk8("frame byte 1", 8'h3c, d1);
    $display("test burst finished");
  endtask

  // Mid-run reset clears the volatile registers; the link restarts cleanly
  task automatic t_reset;
    wr_reg(8'h00, 8'h5a);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk8("param after reset", 8'h00, param_reg);
    chk8("slot after reset", 8'h00, slot_marker);
    chk8("length after reset", 8'h00, {2'h0, frame_len});
    repeat (4) @(posedge ref_clk);
    wr_reg(8'h00, 8'h69);
    chk8("param after restart", 8'h69, param_reg);
    $display("test reset finished");
  endtask

  // Beyond the six registers the subaddress is refused
  task automatic t_sub;
    logic a;
    host.start(1'b0);
    host.wbyte({HI, sel, 1'b0}, a);
    host.wbyte(8'h06, a);
    chk1("subaddr six ack", 1'b0, a);
    host.stop;
    $display("test subaddress finished");
  endtask

  initial begin
    rst_n <= 1'b0;
    sel   <= 3'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_select;
    t_param;
    t_slot;
    t_frame;
    t_burst;
    t_reset;
    t_sub;
    give_verdict;
  end

  // Hang guard
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
endmodule

// *** verilog/cc_consts.svh ***
// Constants for the contactless coupler two-wire target interface
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CC_REG_PARAM   3'h0
`define CC_REG_FRAME   3'h1
`define CC_REG_SLOT    3'h3
`define CC_REG_COUNT   3'h6
`define CC_REG_RST     8'h00

// ****************************************************************
// Serial framing
// ****************************************************************
`define CC_BYTE_BITS   4'h8
`define CC_FRAME_MAX   6'h24
`define CC_ADDR_HI_DEF 4'ha
`define CC_SHIFT_RST   8'h00

`endif

// *** verilog/cc_i2c_target.sv ***
// Two-wire serial target with select-pin addressing and six volatile registers
`timescale 1ns/1ns
`include "cc_consts.svh"

module cc_i2c_target
  import cc_pkg::*;
#(
  parameter logic [3:0] ADDR_HI = `CC_ADDR_HI_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_select_in_bit1,
  input  wire logic       addr_select_in_bit2,
  input  wire logic       addr_select_in_bit3,
  output logic [7:0]      param_reg,
  output logic [7:0]      slot_marker,
  output logic            slot_write,
  output logic            frame_send,
  output logic [5:0]      frame_len
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic       scl_meta, scl_sync, scl_prev;
  logic       sda_meta, sda_sync, sda_prev;
  logic [2:0] sel_meta, sel_sync;

  // Two flops per pin; the bench clock on scl is far below ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      // Open select pins arrive as 0 from the pad pull-downs
      sel_meta <= {addr_select_in_bit3, addr_select_in_bit2, addr_select_in_bit1};
      sel_sync <= sel_meta;
    end
  end

  // Bus events, all decoded on ref_clk from the synchronised pins; start and stop are data edges while the clock is high
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_sync & ~scl_prev;
  assign scl_fall  = ~scl_sync & scl_prev;
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] regs [0:5];
  logic [7:0] frame_mem [0:35];
  logic       reg_we, mem_we;
  logic [7:0] wr_data;

  cc_state_t  state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic       rw, next_rw;
  logic [2:0] ptr, next_ptr;
  logic [5:0] idx, next_idx;
  logic [5:0] frame_cnt, next_frame_cnt;
  logic       frame_wr, next_frame_wr;
  logic       next_sda_oe, next_frame_send, next_slot_write;
  logic [5:0] next_frame_len;
  logic       addr_match;
  logic [7:0] rd_byte;

  // Present select levels feed every compare, so dynamic drive works
  assign addr_match = (shreg[7:1] == {ADDR_HI, sel_sync});
  assign rd_byte    = (ptr == `CC_REG_FRAME) ? frame_mem[idx] : regs[ptr];
  assign param_reg  = regs[`CC_REG_PARAM];
  assign slot_marker = regs[`CC_REG_SLOT];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_rw         = rw;
    next_ptr        = ptr;
    next_idx        = idx;
    next_frame_cnt  = frame_cnt;
    next_frame_wr   = frame_wr;
    next_sda_oe     = sda_oe;
    next_frame_send = 1'b0;
    next_slot_write = 1'b0;
    next_frame_len  = frame_len;
    reg_we          = 1'b0;
    mem_we          = 1'b0;
    wr_data         = shreg;
    if (start_det) begin
      next_state   = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_det) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
      // A completed frame write hands the request to the radio side
      if (frame_wr && (frame_cnt != 6'h00)) begin
        next_frame_send = 1'b1;
        next_frame_len  = frame_cnt;
      end
      next_frame_wr = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_REG, ST_WR: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda_sync};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && (bit_cnt == `CC_BYTE_BITS)) begin
            if (state == ST_ADDR) begin
              if (addr_match) begin
                next_sda_oe = 1'b1;
                next_rw     = shreg[0];
                next_state  = ST_ACK_ADDR;
              end else begin
                next_state = ST_IDLE;
              end
            end else if (state == ST_REG) begin
              // Unmapped sub-addresses are not acknowledged
              if (shreg < {5'h00, `CC_REG_COUNT}) begin
                next_ptr       = shreg[2:0];
                next_idx       = 6'h00;
                next_frame_cnt = 6'h00;
                next_frame_wr  = (shreg[2:0] == `CC_REG_FRAME);
                next_sda_oe    = 1'b1;
                next_state     = ST_ACK_REG;
              end else begin
                next_state = ST_IDLE;
              end
            end else if (ptr == `CC_REG_FRAME) begin
              // Bytes past the buffer end get no acknowledge
              if (idx < `CC_FRAME_MAX) begin
                mem_we         = 1'b1;
                next_idx       = idx + 6'h01;
                next_frame_cnt = frame_cnt + 6'h01;
                next_sda_oe    = 1'b1;
                next_state     = ST_ACK_WR;
              end else begin
                next_state = ST_IDLE;
              end
            end else begin
              reg_we          = 1'b1;
              next_slot_write = (ptr == `CC_REG_SLOT);
              next_sda_oe     = 1'b1;
              next_state      = ST_ACK_WR;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WR: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if ((state == ST_ACK_ADDR) && rw) begin
              next_shreg  = rd_byte;
              next_sda_oe = ~rd_byte[7];
              next_state  = ST_RD;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = (state == ST_ACK_ADDR) ? ST_REG : ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == `CC_BYTE_BITS) begin
              next_sda_oe = 1'b0;
              next_state  = ST_RD_ACK;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
            end
          end
        end
        ST_RD_ACK: begin
          // Host not acknowledging ends the read
          if (scl_rise) begin
            next_state = sda_sync ? ST_IDLE : ST_RD_LOAD;
          end
        end
        ST_RD_LOAD: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if ((ptr == `CC_REG_FRAME) && (idx < `CC_FRAME_MAX - 6'h01)) begin
              next_idx = idx + 6'h01;
            end
            next_shreg  = (ptr == `CC_REG_FRAME) ? frame_mem[next_idx] : regs[ptr];
            next_sda_oe = ~next_shreg[7];
            next_state  = ST_RD;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= `CC_SHIFT_RST;
      rw         <= 1'b0;
      ptr        <= `CC_REG_PARAM;
      idx        <= 6'h00;
      frame_cnt  <= 6'h00;
      frame_wr   <= 1'b0;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
      frame_send <= 1'b0;
      frame_len  <= 6'h00;
      slot_write <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      rw         <= next_rw;
      ptr        <= next_ptr;
      idx        <= next_idx;
      frame_cnt  <= next_frame_cnt;
      frame_wr   <= next_frame_wr;
      sda_oe     <= next_sda_oe;
      sda_out    <= 1'b0;
      frame_send <= next_frame_send;
      frame_len  <= next_frame_len;
      slot_write <= next_slot_write;
    end
  end

  // Storage writes; contents are lost with power, cleared on reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `CC_REG_COUNT; i++) begin
        regs[i] <= `CC_REG_RST;
      end
    end else if (reg_we) begin
      regs[ptr] <= wr_data;
    end
  end

  // Frame buffer has no reset; a read before any write returns unknown data
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      frame_mem[idx] <= wr_data;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  foreign_nack_a: assert property ((state == ST_ADDR) && scl_fall && !start_det && !stop_det
      && (bit_cnt == `CC_BYTE_BITS) && !addr_match |=> !sda_oe && (state == ST_IDLE))
    else $error("foreign address acknowledged");
  match_ack_a: assert property ((state == ST_ADDR) && scl_fall && !start_det && !stop_det
      && (bit_cnt == `CC_BYTE_BITS) && addr_match |=> sda_oe ##1 (state == ST_ACK_ADDR))
    else $error("matching address not acknowledged");
  select_used_a: assert property ($rose(sda_oe) && ($past(state) == ST_ADDR)
      |-> ($past(shreg[3:1]) == $past(sel_sync)) && ($past(shreg[7:4]) == ADDR_HI))
    else $error("acknowledge without select match");
  oe_on_fall_a: assert property ($changed(sda_oe)
      |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("data line changed off a clock fall");
  msb_first_a: assert property ((state == ST_RD) && scl_fall && !start_det && !stop_det
      && (bit_cnt != `CC_BYTE_BITS) |=> sda_oe == ~$past(shreg[6]))
    else $error("read bit order wrong");
  frame_cap_a: assert property (frame_cnt <= `CC_FRAME_MAX)
    else $error("frame buffer overrun");
  frame_send_a: assert property (frame_send |-> $past(stop_det) && $past(frame_wr)
      && (frame_len == $past(frame_cnt)) ##1 !frame_send)
    else $error("frame request without stop");
  ptr_range_a: assert property (ptr < `CC_REG_COUNT)
    else $error("register pointer out of range");

  frame_sent_c: cover property (frame_send && (frame_len > 6'h01));
  read_done_c:  cover property ((state == ST_RD_ACK) ##[1:200] (state == ST_RD_LOAD));
  foreign_c:    cover property ((state == ST_ADDR) ##[1:200] (state == ST_IDLE) && !sda_oe);

endmodule

// *** verilog/cc_pkg.sv ***
// Types shared by the contactless coupler target interface
package cc_pkg;

  // ****************************************************************
  // Serial target states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_REG,
    ST_ACK_REG,
    ST_WR,
    ST_ACK_WR,
    ST_RD,
    ST_RD_ACK,
    ST_RD_LOAD
  } cc_state_t;

endpackage
